//--- hw/ivl_ctrl.sv
// interrupt vector resolution and low-power wake control
`timescale 1ns/100ps
module ivl_ctrl #(
    parameter int NUM_SLOTS = ivl_pkg::NUM_SLOTS
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // reset sources and fetch watch
    input wire ivl_pkg::ivl_rst_src_t rst_src_i,
    input wire logic fetch_i,
    input wire logic [15:0] fetch_addr_i,
    // system nmi flags: supervisor/delay, vacant, mailbox in, mailbox out
    input wire logic [3:0] sys_nmi_flag_i,
    input wire logic [3:0] sys_nmi_en_i,
    // user nmi flags: ext_nmi_flag, osc_fault_flag, flash_access_violation_flag
    input wire logic [2:0] usr_nmi_flag_i,
    input wire logic [2:0] usr_nmi_en_i,
    // maskable sources, each group ORed and qualified by its slot enable and the global enable
    input wire logic [3:0] comp_flag_i,
    input wire logic watchdog_flag_i,
    input wire logic [1:0] serial_a_flag_i,
    input wire logic [3:0] serial_b_flag_i,
    input wire logic t0_c0_flag_i,
    input wire logic [4:0] t0_multi_flag_i,
    input wire logic [3:0] radio_iface_flag_i,
    input wire logic [3:0] radio_core_flag_i,
    input wire logic [2:0] dma_flag_i,
    input wire logic t1_c0_flag_i,
    input wire logic [2:0] t1_multi_flag_i,
    input wire logic [7:0] port1_flag_i,
    input wire logic [7:0] port2_flag_i,
    input wire logic [NUM_SLOTS-1:0] slot_en_i,
    input wire logic global_en_i,
    // core handshake
    input wire logic ack_i,
    input wire logic reti_i,
    input wire logic sleep_req_i,
    input wire ivl_pkg::ivl_sleep_t sleep_level_i,
    // vector answer
    output ivl_pkg::ivl_vec_t vec_o,
    output logic periph_fetch_rst_o,
    // cause words
    output logic [4:0] reset_cause_vector_o,
    output logic [4:0] system_nmi_vector_o,
    output logic [4:0] user_nmi_vector_o,
    output logic [4:0] comparator_vector_o,
    output logic [4:0] serial_a_vector_o,
    output logic [4:0] serial_b_vector_o,
    output logic [4:0] timer0_vector_o,
    output logic [4:0] radio_iface_vector_o,
    output logic [4:0] radio_core_vector_o,
    output logic [4:0] dma_vector_o,
    output logic [4:0] timer1_vector_o,
    output logic [4:0] port1_vector_o,
    output logic [4:0] port2_vector_o,
    // power state
    output ivl_pkg::ivl_sleep_t sleep_level_o,
    output ivl_pkg::ivl_clk_en_t clk_en_o
);
    // slot address table; index order is priority order
    function automatic logic [15:0] slot_addr(input logic [3:0] s);
        case (s)
            4'h0: slot_addr = ivl_pkg::VEC_RESET;
            4'h1: slot_addr = ivl_pkg::VEC_SYS_NMI;
            4'h2: slot_addr = ivl_pkg::VEC_USR_NMI;
            4'h3: slot_addr = ivl_pkg::VEC_COMP;
            4'h4: slot_addr = ivl_pkg::VEC_WDT;
            4'h5: slot_addr = ivl_pkg::VEC_SER_A;
            4'h6: slot_addr = ivl_pkg::VEC_SER_B;
            4'h7: slot_addr = ivl_pkg::VEC_T0_C0;
            4'h8: slot_addr = ivl_pkg::VEC_T0_MULTI;
            4'h9: slot_addr = ivl_pkg::VEC_RADIO;
            4'hA: slot_addr = ivl_pkg::VEC_DMA;
            4'hB: slot_addr = ivl_pkg::VEC_T1_C0;
            4'hC: slot_addr = ivl_pkg::VEC_T1_MULTI;
            4'hD: slot_addr = ivl_pkg::VEC_PORT1;
            4'hE: slot_addr = ivl_pkg::VEC_PORT2;
            default: slot_addr = ivl_pkg::VEC_NONE;
        endcase
    endfunction : slot_addr

    // priority number per slot
    function automatic logic [5:0] slot_prio(input logic [3:0] s);
        case (s)
            4'h0: slot_prio = ivl_pkg::PRI_RESET;
            4'h1: slot_prio = ivl_pkg::PRI_SYS_NMI;
            4'h2: slot_prio = ivl_pkg::PRI_USR_NMI;
            4'h3: slot_prio = ivl_pkg::PRI_COMP;
            4'h4: slot_prio = ivl_pkg::PRI_WDT;
            4'h5: slot_prio = ivl_pkg::PRI_SER_A;
            4'h6: slot_prio = ivl_pkg::PRI_SER_B;
            4'h7: slot_prio = ivl_pkg::PRI_T0_C0;
            4'h8: slot_prio = ivl_pkg::PRI_T0_MULTI;
            4'h9: slot_prio = ivl_pkg::PRI_RADIO;
            4'hA: slot_prio = ivl_pkg::PRI_DMA;
            4'hB: slot_prio = ivl_pkg::PRI_T1_C0;
            4'hC: slot_prio = ivl_pkg::PRI_T1_MULTI;
            4'hD: slot_prio = ivl_pkg::PRI_PORT1;
            4'hE: slot_prio = ivl_pkg::PRI_PORT2;
            default: slot_prio = 6'h00;
        endcase
    endfunction : slot_prio

    // cause word: twice the lowest set flag index plus two, zero when idle
    function automatic logic [4:0] cause_word(input logic [7:0] f);
        cause_word = ivl_pkg::CAUSE_NONE;
        for (int i = 7; i >= 0; i--) begin
            if (f[i]) begin
                cause_word = 5'((i + 1) * 2);
            end
        end
    endfunction : cause_word

    // state: wake/service FSM, saved level, latched reset cause
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_SERVICE = 3'b100
    } ivl_state_t;

    ivl_state_t state_reg, state_next;
    ivl_pkg::ivl_sleep_t level_reg, level_next;
    ivl_pkg::ivl_sleep_t saved_reg, saved_next;
    logic [4:0] rst_flag_reg;
    ivl_pkg::ivl_vec_t vec_reg;
    logic periph_rst_reg;
    logic [NUM_SLOTS-1:0] pend;
    logic any_pend;
    logic [3:0] win_idx;
    logic mask_ok;
    logic bad_fetch;

    assign bad_fetch = fetch_i && (fetch_addr_i <= ivl_pkg::PERIPH_TOP);

    assign mask_ok = global_en_i;

    // pending requests per slot
    assign pend[0] = |rst_flag_reg;
    assign pend[1] = |(sys_nmi_flag_i & sys_nmi_en_i) && slot_en_i[1];
    assign pend[2] = |(usr_nmi_flag_i & usr_nmi_en_i) && slot_en_i[2];
    assign pend[3] = |comp_flag_i && slot_en_i[3] && mask_ok;
    assign pend[4] = watchdog_flag_i && slot_en_i[4] && mask_ok;
    assign pend[5] = |serial_a_flag_i && slot_en_i[5] && mask_ok;
    assign pend[6] = |serial_b_flag_i && slot_en_i[6] && mask_ok;
    assign pend[7] = t0_c0_flag_i && slot_en_i[7] && mask_ok;
    assign pend[8] = |t0_multi_flag_i && slot_en_i[8] && mask_ok;
    assign pend[9] = (|radio_iface_flag_i || |radio_core_flag_i) && slot_en_i[9] && mask_ok;
    assign pend[10] = |dma_flag_i && slot_en_i[10] && mask_ok;
    assign pend[11] = t1_c0_flag_i && slot_en_i[11] && mask_ok;
    assign pend[12] = |t1_multi_flag_i && slot_en_i[12] && mask_ok;
    assign pend[13] = |port1_flag_i && slot_en_i[13] && mask_ok;
    assign pend[14] = |port2_flag_i && slot_en_i[14] && mask_ok;
    assign pend[NUM_SLOTS-1] = 1'b0; // spare slot, never requests

    ivl_prio_enc #(
        .N(NUM_SLOTS)
    ) u_prio (
        .req_i(pend),
        .any_o(any_pend),
        .idx_o(win_idx)
    );

    always_comb begin
        state_next = state_reg;
        level_next = level_reg;
        saved_next = saved_reg;
        case (state_reg)
            ST_RUN: begin
                if (any_pend && ack_i) begin
                    saved_next = ivl_pkg::full_run_mode;
                    state_next = ST_SERVICE;
                end else if (sleep_req_i && sleep_level_i != ivl_pkg::full_run_mode) begin
                    level_next = sleep_level_i;
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (any_pend) begin
                    saved_next = level_reg;
                    level_next = ivl_pkg::full_run_mode;
                    state_next = ST_RUN;
                end
            end
            ST_SERVICE: begin
                if (reti_i) begin
                    level_next = saved_reg;
                    state_next = (saved_reg == ivl_pkg::full_run_mode) ? ST_RUN : ST_SLEEP;
                end
            end
            default: begin
                state_next = ST_RUN;
                level_next = ivl_pkg::full_run_mode;
            end
        endcase
    end

    // FSM note: wake goes through RUN so the core must ack before service;
    // the saved level is only overwritten by a wake, so nested acks keep it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_RUN;
            level_reg <= ivl_pkg::ivl_sleep_t'(ivl_pkg::SLEEP_RST);
            saved_reg <= ivl_pkg::ivl_sleep_t'(ivl_pkg::SLEEP_RST);
        end else begin
            state_reg <= (state_reg == ST_RUN && saved_reg != ivl_pkg::full_run_mode
                          && any_pend && ack_i) ? ST_SERVICE : state_next;
            level_reg <= level_next;
            saved_reg <= (state_reg == ST_RUN && saved_reg != ivl_pkg::full_run_mode)
                         ? saved_reg : saved_next;
        end
    end

    // reset causes latched; set wins over the ack that clears them
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rst_flag_reg <= 5'h10;
            periph_rst_reg <= 1'b0;
        end else begin
            rst_flag_reg <= (ack_i && win_idx == 4'h0 ? 5'h00 : rst_flag_reg)
                            | rst_src_i | {bad_fetch, 4'h0};
            periph_rst_reg <= bad_fetch;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            vec_reg <= '0;
        end else begin
            vec_reg.valid <= any_pend;
            vec_reg.addr <= any_pend ? slot_addr(win_idx) : ivl_pkg::VEC_NONE;
            vec_reg.prio <= any_pend ? slot_prio(win_idx) : 6'h00;
            vec_reg.slot <= win_idx;
        end
    end

    // clock enables follow the current level
    ivl_clk_gate_ctrl u_gate (
        .level_i(level_reg),
        .en_o(clk_en_o)
    );

    // outputs
    assign vec_o = vec_reg;
    assign periph_fetch_rst_o = periph_rst_reg;
    assign sleep_level_o = level_reg;
    assign reset_cause_vector_o = cause_word({3'h0, rst_flag_reg});
    assign system_nmi_vector_o = cause_word({4'h0, sys_nmi_flag_i & sys_nmi_en_i});
    assign user_nmi_vector_o = cause_word({5'h0, usr_nmi_flag_i & usr_nmi_en_i});
    assign comparator_vector_o = cause_word({4'h0, comp_flag_i});
    assign serial_a_vector_o = cause_word({6'h00, serial_a_flag_i});
    assign serial_b_vector_o = cause_word({4'h0, serial_b_flag_i});
    assign timer0_vector_o = cause_word({3'h0, t0_multi_flag_i});
    assign radio_iface_vector_o = cause_word({4'h0, radio_iface_flag_i});
    assign radio_core_vector_o = cause_word({4'h0, radio_core_flag_i});
    assign dma_vector_o = cause_word({5'h00, dma_flag_i});
    assign timer1_vector_o = cause_word({5'h00, t1_multi_flag_i});
    assign port1_vector_o = cause_word(port1_flag_i);
    assign port2_vector_o = cause_word(port2_flag_i);
endmodule : ivl_ctrl

//--- inc/ivl_pkg.sv
// package: vector slots, priorities, sleep-level encodings and carrier structs
package ivl_pkg;
    // vector table bounds (byte addresses)
    localparam logic [15:0] VEC_TOP = 16'hFFFF;
    localparam logic [15:0] VEC_LOW = 16'hFF80;
    localparam int NUM_SLOTS = 16;
    // slot index order is priority order, index 0 highest
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_SYS_NMI = 16'hFFFC;
    localparam logic [15:0] VEC_USR_NMI = 16'hFFFA;
    localparam logic [15:0] VEC_COMP = 16'hFFF8;
    localparam logic [15:0] VEC_WDT = 16'hFFF6;
    localparam logic [15:0] VEC_SER_A = 16'hFFF4;
    localparam logic [15:0] VEC_SER_B = 16'hFFF2;
    localparam logic [15:0] VEC_T0_C0 = 16'hFFEE;
    localparam logic [15:0] VEC_T0_MULTI = 16'hFFEC;
    localparam logic [15:0] VEC_RADIO = 16'hFFEA;
    localparam logic [15:0] VEC_DMA = 16'hFFE8;
    localparam logic [15:0] VEC_T1_C0 = 16'hFFE6;
    localparam logic [15:0] VEC_T1_MULTI = 16'hFFE4;
    localparam logic [15:0] VEC_PORT1 = 16'hFFE2;
    localparam logic [15:0] VEC_PORT2 = 16'hFFE0;
    localparam logic [15:0] VEC_NONE = 16'h0000;
    // priority numbers per slot
    localparam logic [5:0] PRI_RESET = 6'h3F;
    localparam logic [5:0] PRI_SYS_NMI = 6'h3E;
    localparam logic [5:0] PRI_USR_NMI = 6'h3D;
    localparam logic [5:0] PRI_COMP = 6'h3C;
    localparam logic [5:0] PRI_WDT = 6'h3B;
    localparam logic [5:0] PRI_SER_A = 6'h3A;
    localparam logic [5:0] PRI_SER_B = 6'h39;
    localparam logic [5:0] PRI_T0_C0 = 6'h37;
    localparam logic [5:0] PRI_T0_MULTI = 6'h36;
    localparam logic [5:0] PRI_RADIO = 6'h35;
    localparam logic [5:0] PRI_DMA = 6'h34;
    localparam logic [5:0] PRI_T1_C0 = 6'h33;
    localparam logic [5:0] PRI_T1_MULTI = 6'h32;
    localparam logic [5:0] PRI_PORT1 = 6'h31;
    localparam logic [5:0] PRI_PORT2 = 6'h30;
    // peripheral address region upper bound
    localparam logic [15:0] PERIPH_TOP = 16'h0FFF;
    // cause-word encodings: 2 * (flag index + 1), 0 when none
    localparam logic [4:0] CAUSE_NONE = 5'h00;
    // reset values
    localparam logic [2:0] SLEEP_RST = 3'h0;

    // sleep levels, as selected by software
    typedef enum logic [2:0] {
        full_run_mode = 3'h0,
        sleep_level_0 = 3'h1,
        sleep_level_1 = 3'h2,
        sleep_level_2 = 3'h3,
        sleep_level_3 = 3'h4,
        sleep_level_4 = 3'h5
    } ivl_sleep_t;

    // clock gating enables, one per clock resource
    typedef struct packed {
        logic core_run;
        logic main_clk;
        logic sub_main_clock;
        logic aux_clk;
        logic fast_osc_clock;
        logic fast_osc_bias;
        logic freq_lock_loop;
        logic crystal_osc;
    } ivl_clk_en_t;

    // reset sources sharing the top slot
    typedef struct packed {
        logic power_up;
        logic ext_reset;
        logic watchdog_flag;
        logic password_violation_flag;
        logic flash_key_violation;
    } ivl_rst_src_t;

    // vector answer to the core
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [5:0] prio;
        logic [3:0] slot;
    } ivl_vec_t;
endpackage : ivl_pkg

//--- hw/ivl_prio_enc.sv
// fixed-priority encoder picking the lowest-index pending slot
`timescale 1ns/100ps
module ivl_prio_enc #(
    parameter int N = 16
) (
    // request vector, index 0 highest
    input wire logic [N-1:0] req_i,
    // result
    output logic any_o,
    output logic [3:0] idx_o
);
    // downward scan so the last hit is the highest priority
    always_comb begin
        any_o = 1'b0;
        idx_o = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                any_o = 1'b1;
                idx_o = 4'(i);
            end
        end
    end
endmodule : ivl_prio_enc

//--- hw/ivl_clk_gate_ctrl.sv
// clock and oscillator enables for each sleep level
`timescale 1ns/100ps
module ivl_clk_gate_ctrl (
    // selected level
    input wire ivl_pkg::ivl_sleep_t level_i,
    // enables
    output ivl_pkg::ivl_clk_en_t en_o
);
    // each level stops a strict superset of the previous one
    always_comb begin
        en_o = '1;
        case (level_i)
            ivl_pkg::full_run_mode: begin
                en_o = '1;
            end
            ivl_pkg::sleep_level_0: begin
                en_o.core_run = 1'b0;
                en_o.main_clk = 1'b0;
            end
            ivl_pkg::sleep_level_1: begin
                en_o.core_run = 1'b0;
                en_o.main_clk = 1'b0;
                en_o.freq_lock_loop = 1'b0;
            end
            ivl_pkg::sleep_level_2: begin
                en_o.core_run = 1'b0;
                en_o.main_clk = 1'b0;
                en_o.freq_lock_loop = 1'b0;
                en_o.fast_osc_clock = 1'b0;
                en_o.sub_main_clock = 1'b0;
            end
            ivl_pkg::sleep_level_3: begin
                en_o = '0;
                en_o.aux_clk = 1'b1;
                en_o.crystal_osc = 1'b1;
            end
            ivl_pkg::sleep_level_4: begin
                en_o = '0;
            end
            default: begin
                en_o = '1;
            end
        endcase
    end
endmodule : ivl_clk_gate_ctrl

//--- sim/ivl_ctrl_chk.sv
// checker: port-level properties of the vector and sleep controller
`timescale 1ns/100ps
module ivl_ctrl_chk #(
    parameter int NUM_SLOTS = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic fetch_i,
    input wire logic [15:0] fetch_addr_i,
    input wire logic global_en_i,
    input wire logic sleep_req_i,
    input wire logic reti_i,
    input wire ivl_pkg::ivl_vec_t vec_o,
    input wire logic periph_fetch_rst_o,
    input wire ivl_pkg::ivl_sleep_t sleep_level_o,
    input wire ivl_pkg::ivl_clk_en_t clk_en_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    fetch_rst_a: assert property (fetch_i && fetch_addr_i <= 16'h0FFF |=> periph_fetch_rst_o)
        else $error("peripheral fetch gave no reset");
    fetch_quiet_a: assert property (!(fetch_i && fetch_addr_i <= 16'h0FFF) |=> !periph_fetch_rst_o)
        else $error("reset without a peripheral fetch");
    vec_range_a: assert property (vec_o.valid |-> vec_o.addr >= 16'hFF80 && !vec_o.addr[0])
        else $error("vector outside the table");
    vec_pair_a: assert property (vec_o.valid |-> vec_o.addr == 16'hFFFE - {9'h000, 6'h3F - vec_o.prio, 1'b0})
        else $error("vector address does not match priority");
    slot_prio_a: assert property (vec_o.valid |-> vec_o.prio == ((vec_o.slot < 4'h7) ?
        6'h3F - {2'h0, vec_o.slot} : 6'h3E - {2'h0, vec_o.slot}))
        else $error("priority does not match slot");
    gie_mask_a: assert property (vec_o.valid && !$past(global_en_i) |-> vec_o.slot <= 4'h2)
        else $error("maskable slot won with global enable off");
    wake_a: assert property ($rose(vec_o.valid) |-> sleep_level_o == ivl_pkg::full_run_mode)
        else $error("vector presented while still asleep");
    sleep_entry_a: assert property ($changed(sleep_level_o) && sleep_level_o != ivl_pkg::full_run_mode
        |-> $past(sleep_req_i) || $past(reti_i))
        else $error("sleep entered without request or return");
    run_clk_a: assert property (sleep_level_o == ivl_pkg::full_run_mode |-> clk_en_o == 8'hFF)
        else $error("clock stopped in run mode");
    lvl0_clk_a: assert property (sleep_level_o == ivl_pkg::sleep_level_0 |-> clk_en_o == 8'h3F)
        else $error("level 0 enables wrong");
    lvl1_clk_a: assert property (sleep_level_o == ivl_pkg::sleep_level_1 |-> clk_en_o == 8'h3D)
        else $error("level 1 enables wrong");
    lvl2_clk_a: assert property (sleep_level_o == ivl_pkg::sleep_level_2 |-> clk_en_o == 8'h15)
        else $error("level 2 enables wrong");
    lvl3_clk_a: assert property (sleep_level_o == ivl_pkg::sleep_level_3 |-> clk_en_o == 8'h11)
        else $error("level 3 enables wrong");
    lvl4_clk_a: assert property (sleep_level_o == ivl_pkg::sleep_level_4 |-> clk_en_o == 8'h00)
        else $error("level 4 enables wrong");
endmodule : ivl_ctrl_chk

bind ivl_ctrl ivl_ctrl_chk #(.NUM_SLOTS(NUM_SLOTS)) chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .fetch_i(fetch_i), .fetch_addr_i(fetch_addr_i), .global_en_i(global_en_i),
    .sleep_req_i(sleep_req_i), .reti_i(reti_i), .vec_o(vec_o),
    .periph_fetch_rst_o(periph_fetch_rst_o), .sleep_level_o(sleep_level_o), .clk_en_o(clk_en_o));

//--- sim/ivl_src_model.sv
// peripheral flag sources, each held until its vector is taken
`timescale 1ns/100ps
module ivl_src_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // bench requests and core acknowledge
    input wire logic [15:0] set_i,
    input wire logic [2:0] sel_i,
    input wire logic ack_i,
    input wire ivl_pkg::ivl_vec_t vec_i,
    // flags
    output logic [3:0] sys_nmi_flag_o,
    output logic [2:0] usr_nmi_flag_o,
    output logic [3:0] comp_flag_o,
    output logic watchdog_flag_o,
    output logic [1:0] serial_a_flag_o,
    output logic [3:0] serial_b_flag_o,
    output logic t0_c0_flag_o,
    output logic [4:0] t0_multi_flag_o,
    output logic [3:0] radio_iface_flag_o,
    output logic [3:0] radio_core_flag_o,
    output logic [2:0] dma_flag_o,
    output logic t1_c0_flag_o,
    output logic [2:0] t1_multi_flag_o,
    output logic [7:0] port1_flag_o,
    output logic [7:0] port2_flag_o
);
    logic [15:0] pend_reg;
    logic [15:0] pend_next;
    logic [15:0] taken_w;
    logic [7:0] pos_w;
    // flag clears on the acknowledge edge, like a vector-word read
    assign taken_w = (ack_i && vec_i.valid) ? (16'h0001 << vec_i.slot) : 16'h0000;
    assign pend_next = (pend_reg | set_i) & ~taken_w;
    // sel picks which flag of a group; too wide a sel leaves the group silent
    assign pos_w = 8'h01 << sel_i;
    assign sys_nmi_flag_o = pos_w[3:0] & {4{pend_reg[1]}};
    assign usr_nmi_flag_o = pos_w[2:0] & {3{pend_reg[2]}};
    assign comp_flag_o = pos_w[3:0] & {4{pend_reg[3]}};
    assign watchdog_flag_o = pend_reg[4];
    assign serial_a_flag_o = pos_w[1:0] & {2{pend_reg[5]}};
    assign serial_b_flag_o = pos_w[3:0] & {4{pend_reg[6]}};
    assign t0_c0_flag_o = pend_reg[7];
    assign t0_multi_flag_o = pos_w[4:0] & {5{pend_reg[8]}};
    assign radio_iface_flag_o = pos_w[3:0] & {4{pend_reg[9]}};
    assign radio_core_flag_o = pos_w[7:4] & {4{pend_reg[9]}};
    assign dma_flag_o = pos_w[2:0] & {3{pend_reg[10]}};
    assign t1_c0_flag_o = pend_reg[11];
    assign t1_multi_flag_o = pos_w[2:0] & {3{pend_reg[12]}};
    assign port1_flag_o = pos_w & {8{pend_reg[13]}};
    assign port2_flag_o = pos_w & {8{pend_reg[14]}};
    // pending state
    always_ff @(posedge ref_clk_i) begin
        pend_reg <= rst_i ? 16'h0000 : pend_next;
    end
endmodule : ivl_src_model

//--- sim/ivl_ctrl_tb_top.sv
// bench: vector table, masking, cause words, sleep levels, fetch guard
`timescale 1ns/100ps
module ivl_ctrl_tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    ivl_pkg::ivl_rst_src_t rst_src_r = '0;
    logic fetch_r = 1'b0;
    logic [15:0] faddr_r = 16'h0000;
    logic [3:0] sys_en_r = 4'hF;
    logic [2:0] usr_en_r = 3'h7;
    logic [15:0] slot_en_r = 16'hFFFF;
    logic gie_r = 1'b1, ack_r = 1'b0, reti_r = 1'b0, sreq_r = 1'b0;
    ivl_pkg::ivl_sleep_t slvl_r = ivl_pkg::full_run_mode;
    logic [15:0] set_r = 16'h0000;
    logic [2:0] sel_r = 3'h0;
    logic [3:0] sys_f, comp_f, serb_f, rif_f, rcore_f;
    logic [4:0] cw [13];
    logic [2:0] usr_f, dma_f, t1m_f;
    logic [1:0] sera_f;
    logic [4:0] t0m_f;
    logic [7:0] p1_f, p2_f;
    logic wdt_f, t0c_f, t1c_f, periph_fetch_rst_o;
    ivl_pkg::ivl_vec_t vec_o;
    ivl_pkg::ivl_sleep_t sleep_level_o;
    ivl_pkg::ivl_clk_en_t clk_en_o;
    int err_total = 0;
    int samples_checked = 0;
    logic [7:0] clk_tab [6] = '{8'hFF, 8'h3F, 8'h3D, 8'h15, 8'h11, 8'h00};
    int ord [4] = '{3, 10, 13, 14};
    int cwi [15] = '{0,1,2,3,0,4,5,0,6,7,9,0,10,11,12};

    // 250 MHz clock
    always #2 ref_clk_i = ~ref_clk_i;

    ivl_src_model src (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .set_i(set_r), .sel_i(sel_r),
        .ack_i(ack_r), .vec_i(vec_o), .sys_nmi_flag_o(sys_f), .usr_nmi_flag_o(usr_f),
        .comp_flag_o(comp_f), .watchdog_flag_o(wdt_f), .serial_a_flag_o(sera_f),
        .serial_b_flag_o(serb_f), .t0_c0_flag_o(t0c_f), .t0_multi_flag_o(t0m_f),
        .radio_iface_flag_o(rif_f), .radio_core_flag_o(rcore_f), .dma_flag_o(dma_f),
        .t1_c0_flag_o(t1c_f), .t1_multi_flag_o(t1m_f), .port1_flag_o(p1_f), .port2_flag_o(p2_f));

    ivl_ctrl #(.NUM_SLOTS(16)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .rst_src_i(rst_src_r),
        .fetch_i(fetch_r), .fetch_addr_i(faddr_r), .sys_nmi_flag_i(sys_f), .sys_nmi_en_i(sys_en_r),
        .usr_nmi_flag_i(usr_f), .usr_nmi_en_i(usr_en_r), .comp_flag_i(comp_f),
        .watchdog_flag_i(wdt_f), .serial_a_flag_i(sera_f), .serial_b_flag_i(serb_f),
        .t0_c0_flag_i(t0c_f), .t0_multi_flag_i(t0m_f), .radio_iface_flag_i(rif_f),
        .radio_core_flag_i(rcore_f), .dma_flag_i(dma_f), .t1_c0_flag_i(t1c_f),
        .t1_multi_flag_i(t1m_f), .port1_flag_i(p1_f), .port2_flag_i(p2_f),
        .slot_en_i(slot_en_r), .global_en_i(gie_r), .ack_i(ack_r), .reti_i(reti_r),
        .sleep_req_i(sreq_r), .sleep_level_i(slvl_r), .vec_o(vec_o),
        .periph_fetch_rst_o(periph_fetch_rst_o), .reset_cause_vector_o(cw[0]),
        .system_nmi_vector_o(cw[1]), .user_nmi_vector_o(cw[2]), .comparator_vector_o(cw[3]),
        .serial_a_vector_o(cw[4]), .serial_b_vector_o(cw[5]), .timer0_vector_o(cw[6]),
        .radio_iface_vector_o(cw[7]), .radio_core_vector_o(cw[8]), .dma_vector_o(cw[9]),
        .timer1_vector_o(cw[10]), .port1_vector_o(cw[11]), .port2_vector_o(cw[12]),
        .sleep_level_o(sleep_level_o), .clk_en_o(clk_en_o));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // settle past the edge before sampling
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick

    task automatic raise(input logic [15:0] m, input logic [2:0] s);
        @(posedge ref_clk_i);
        set_r <= m;
        sel_r <= s;
        @(posedge ref_clk_i);
        set_r <= 16'h0000;
        tick(1);
    endtask : raise

    // wait for a vector, check it, acknowledge, then return
    task automatic serve_slot(input int s);
        int n;
        logic [5:0] p;
        n = 0;
        p = (s < 7) ? 6'(63 - s) : 6'(62 - s);
        while (vec_o.valid !== 1'b1) begin
            tick(1);
            n++;
            if (n > 40) begin
                err_total++;
                complete_run();
            end
        end
        check("vec_addr", vec_o.addr, 16'hFFFE - {9'h000, 6'h3F - p, 1'b0});
        check("vec_prio", vec_o.prio, p);
        check("wake_level", sleep_level_o, ivl_pkg::full_run_mode);
        @(posedge ref_clk_i);
        ack_r <= 1'b1;
        @(posedge ref_clk_i);
        ack_r <= 1'b0;
        tick(2);
        @(posedge ref_clk_i);
        reti_r <= 1'b1;
        @(posedge ref_clk_i);
        reti_r <= 1'b0;
        tick(1);
    endtask : serve_slot

    // reset 8 cycles, then take the power-up vector
    task automatic do_reset;
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        check("reset_cause", cw[0], 5'h0A);
        serve_slot(0);
    endtask : do_reset

    initial begin
        do_reset();
        for (int s = 1; s < 15; s++) begin
            raise(16'h0001 << s, 3'h0);
            check("cause_word", cw[cwi[s]], cwi[s] ? 2 : 0);
            serve_slot(s);
        end
        raise(16'h6408, 3'h0);
        foreach (ord[i]) serve_slot(ord[i]);
        // global enable off, nmi still served
        @(posedge ref_clk_i);
        gie_r <= 1'b0;
        usr_en_r <= 3'h0;
        raise(16'h2004, 3'h0);
        tick(3);
        check("masked_valid", vec_o.valid, 1'b0);
        @(posedge ref_clk_i);
        usr_en_r <= 3'h7;
        serve_slot(2);
        @(posedge ref_clk_i);
        gie_r <= 1'b1;
        serve_slot(13);
        raise(16'h2000, 3'h7);
        check("port1_cause", cw[11], 5'h10);
        serve_slot(13);
        raise(16'h0100, 3'h4);
        check("timer0_cause", cw[6], 4'hA);
        serve_slot(8);
        raise(16'h0400, 3'h2);
        check("dma_cause", cw[9], 4'h6);
        serve_slot(10);
        raise(16'h0200, 3'h5);
        check("radio_cause", cw[8], 4'h4);
        serve_slot(9);
        // each sleep level, wake and restore
        for (int l = 1; l < 6; l++) begin
            @(posedge ref_clk_i);
            sreq_r <= 1'b1;
            slvl_r <= ivl_pkg::ivl_sleep_t'(3'(l));
            @(posedge ref_clk_i);
            sreq_r <= 1'b0;
            tick(1);
            check("sleep_level", sleep_level_o, l);
            check("clk_enables", clk_en_o, clk_tab[l]);
            raise(16'h2000, 3'h0);
            serve_slot(13);
            check("restored", sleep_level_o, l);
            do_reset();
        end
        // fetch guard at the region boundary
        @(posedge ref_clk_i);
        fetch_r <= 1'b1;
        faddr_r <= 16'h1000;
        @(posedge ref_clk_i);
        faddr_r <= 16'h0FFF;
        #1 check("fetch_reset", periph_fetch_rst_o, 1'b0);
        @(posedge ref_clk_i);
        fetch_r <= 1'b0;
        #1 check("fetch_reset", periph_fetch_rst_o, 1'b1);
        serve_slot(0);
        @(posedge ref_clk_i);
        rst_src_r.ext_reset <= 1'b1;
        @(posedge ref_clk_i);
        rst_src_r.ext_reset <= 1'b0;
        serve_slot(0);
        complete_run();
    end
endmodule : ivl_ctrl_tb_top
